// File: hw/iopfm_pkg.sv
// Constants, register map and field layouts of the I/O port function mux.
// Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
`default_nettype none
package iopfm_pkg;
   localparam int NPIN = 64;
   localparam int NIRQ = 6;
   localparam int NDMA = 4;
   localparam int NTMR = 6;
   // Byte addresses
   localparam logic [31:0] ADDR_DIR_LO = 32'hF0030000;
   localparam logic [31:0] ADDR_DIR_HI = 32'hF0030004;
   localparam logic [31:0] ADDR_FSEL_LO = 32'hF0030008;
   localparam logic [31:0] ADDR_FSEL_HI = 32'hF003000C;
   localparam logic [31:0] ADDR_DMA_CFG = 32'hF0030010;
   localparam logic [31:0] ADDR_IRQ_CFG = 32'hF0030014;
   localparam logic [31:0] ADDR_IRQ_PEND = 32'hF0030018;
   localparam logic [31:0] ADDR_DATA_LO = 32'hF003001C;
   localparam logic [31:0] ADDR_DATA_HI = 32'hF0030020;
   localparam logic [31:0] ADDR_DRV_LO = 32'hF0030024;
   localparam logic [31:0] ADDR_DRV_HI = 32'hF0030028;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'hF003002C;
   // Register indices from the decoder
   localparam logic [3:0] RI_DIR_LO = 4'h0;
   localparam logic [3:0] RI_DIR_HI = 4'h1;
   localparam logic [3:0] RI_FSEL_LO = 4'h2;
   localparam logic [3:0] RI_FSEL_HI = 4'h3;
   localparam logic [3:0] RI_DMA_CFG = 4'h4;
   localparam logic [3:0] RI_IRQ_CFG = 4'h5;
   localparam logic [3:0] RI_IRQ_PEND = 4'h6;
   localparam logic [3:0] RI_DATA_LO = 4'h7;
   localparam logic [3:0] RI_DATA_HI = 4'h8;
   localparam logic [3:0] RI_DRV_LO = 4'h9;
   localparam logic [3:0] RI_DRV_HI = 4'hA;
   localparam logic [3:0] RI_IRQ_MASK = 4'hB;
   localparam logic [3:0] RI_NONE = 4'hF;
   // Reset values
   localparam logic [31:0] RST_DIR_LO = 32'hF003FFFF;
   localparam logic [31:0] RST_DIR_HI = 32'h0FFFFFFF;
   localparam logic [31:0] RST_FSEL_LO = 32'h0FFFFF00;
   localparam logic [31:0] RST_FSEL_HI = 32'hFFFFFC07;
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [31:0] DMA_CFG_BITS = 32'h00000FFF;
   localparam logic [31:0] IRQ_CFG_BITS = 32'h00FFFFFF;
   // Pin map of the dedicated functions
   localparam int PIN_IRQ0 = 0;
   localparam int PIN_TMR0 = 6;
   localparam int PIN_DMA_REQ0 = 14;
   localparam int PIN_DMA_ACK0 = 28;
   localparam int PIN_FS_RX = 35;
   localparam int PIN_FS_TX = 36;
   localparam int PIN_FS_DTR = 37;
   localparam int PIN_FS_DSR = 38;
   localparam int PIN_FS_RTS = 39;
   localparam int PIN_FS_CTS = 40;
   localparam int PIN_FS_DCD = 41;
   localparam logic [63:0] FN_AVAIL = 64'h000003F8F003CFFF;
   localparam logic [63:0] FN_IS_OUT = 64'h000000B0F0000FC0;
   localparam logic [63:0] RST_PULSE_PINS = 64'h000000000FFC0000;
   // Reset pulse on the external-reset pins
   localparam int CLK_PERIOD_NS = 5;
   localparam int RST_PULSE_NS = 1000;
   localparam logic [15:0] RST_PULSE_CYC = 16'(RST_PULSE_NS / CLK_PERIOD_NS);
   // External interrupt detection modes
   localparam logic [1:0] MODE_LEVEL = 2'h0;
   localparam logic [1:0] MODE_RISE = 2'h1;
   localparam logic [1:0] MODE_FALL = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] mode;
      logic act_low;
      logic filt_en;
   } iopfm_irq_cfg_t;

   typedef struct packed {
      logic [3:0] ack_low;
      logic [3:0] req_low;
      logic [3:0] filt_en;
   } iopfm_dma_cfg_t;

   typedef enum logic {RP_HIGH, RP_DONE} iopfm_rp_state_t;

   function automatic logic [31:0] iopfm_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : iopfm_strb
endpackage : iopfm_pkg
`default_nettype wire

// File: hw/iopfm_filt.sv
// Two-flop synchroniser for every pin plus a selectable 3-tap filter.
// Assumes raw pins are asynchronous to aclk.
`default_nettype none
module iopfm_filt
   import iopfm_pkg::*;
#(
   parameter int W = NPIN
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] raw,
   input wire logic [W-1:0] filt_en,
   output logic [W-1:0] sync_q,
   output logic [W-1:0] filt_q
);
   logic [W-1:0] s1_r, s2_r, t1_r, t2_r, hold_r, hold_nxt, all_hi, all_lo;

   assign all_hi = s2_r & t1_r & t2_r;
   assign all_lo = ~(s2_r | t1_r | t2_r);
   // Output only moves once three samples agree
   assign hold_nxt = (hold_r & ~all_lo) | all_hi;
   assign sync_q = s2_r;
   assign filt_q = (filt_en & hold_r) | (~filt_en & s2_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
         t1_r <= '0;
         t2_r <= '0;
         hold_r <= '0;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         t1_r <= s2_r;
         t2_r <= t1_r;
         hold_r <= hold_nxt;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_FILT_THREE: assert property ((hold_r & ~$past(hold_r) & ~$past(all_hi)) == '0) else $error("filter rose without three high samples");
endmodule : iopfm_filt
`default_nettype wire

// File: hw/iopfm_edge.sv
// Rising and falling edge detector on already synchronised levels.
// Assumes lvl comes from flops on aclk.
`default_nettype none
module iopfm_edge
   import iopfm_pkg::*;
#(
   parameter int W = NIRQ
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] prev_r;

   assign rise = lvl & ~prev_r;
   assign fall = ~lvl & prev_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= '0;
      end else begin
         prev_r <= lvl;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_EDGE_RISE: assert property (rise[0] |-> lvl[0] && !$past(lvl[0])) else $error("rise without a low-to-high step");
endmodule : iopfm_edge
`default_nettype wire

// File: hw/iopfm_top.sv
// Operation
// - pin 14 low select bit zero gives DMA request
// - select registers choose GPIO or dedicated function
// - high select bits 3-9 pick fast UART lines
// - function pins follow DMA or interrupt config
// - switchable 3-tap filter on DMA and interrupt inputs
// - programmable polarity; software matches external signal
// - interrupts detect level, rising or falling edge
// - edge event sets pending bit until cleared
// - writing one to pending bit clears it
// - level mode passes input straight, no latching
// - data bit reads pin input, drives pin output
// - drive bit one open-drain, zero push-pull
// - direction bit one input, zero output
// - pins 18-27 pulse high after reset, then low
// Top of the 64-pin I/O function mux with its AXI4-Lite register slave.
// Assumes pins are asynchronous, function peers run on aclk.
//
// Design decision made here: register access over AXI4-Lite.
`default_nettype none
module iopfm_top
   import iopfm_pkg::*;
#(
   parameter logic [15:0] RESET_PULSE_CYC = RST_PULSE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NPIN-1:0] pin_in,
   output logic [NPIN-1:0] pin_out,
   output logic [NPIN-1:0] pin_oe_n,
   output logic [NIRQ-1:0] ext_irq_to_intc,
   output logic irq,
   output logic [NDMA-1:0] general_dma_req,
   input wire logic [NDMA-1:0] general_dma_ack,
   input wire logic [NTMR-1:0] timer_out,
   input wire logic fast_serial_transmit,
   input wire logic fast_serial_terminal_ready,
   input wire logic fast_serial_request_to_send,
   output logic fast_serial_receive,
   output logic fast_serial_set_ready,
   output logic fast_serial_clear_to_send,
   output logic fast_serial_carrier_detect
);
   function automatic logic [3:0] reg_index(input logic [31:0] a);
      logic [3:0] r;
      if (a == ADDR_DIR_LO) r = RI_DIR_LO;
      else if (a == ADDR_DIR_HI) r = RI_DIR_HI;
      else if (a == ADDR_FSEL_LO) r = RI_FSEL_LO;
      else if (a == ADDR_FSEL_HI) r = RI_FSEL_HI;
      else if (a == ADDR_DMA_CFG) r = RI_DMA_CFG;
      else if (a == ADDR_IRQ_CFG) r = RI_IRQ_CFG;
      else if (a == ADDR_IRQ_PEND) r = RI_IRQ_PEND;
      else if (a == ADDR_DATA_LO) r = RI_DATA_LO;
      else if (a == ADDR_DATA_HI) r = RI_DATA_HI;
      else if (a == ADDR_DRV_LO) r = RI_DRV_LO;
      else if (a == ADDR_DRV_HI) r = RI_DRV_HI;
      else if (a == ADDR_IRQ_MASK) r = RI_IRQ_MASK;
      else r = RI_NONE;
      return r;
   endfunction : reg_index

   // Register state
   logic [63:0] dir_r, fsel_r, data_r, drv_r;
   logic [31:0] dma_cfg_r, irq_cfg_r;
   logic [NIRQ-1:0] pend_r, mask_r, pend_nxt;
   // Bus state
   logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
   logic [31:0] awaddr_r, wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   // Pin state
   logic [63:0] pin_out_r, pin_oe_n_r, pin_out_nxt, pin_oe_n_nxt;
   logic [NDMA-1:0] dma_req_r;
   logic [15:0] rp_cnt_r;
   iopfm_rp_state_t rp_state_r;

   // Field views
   iopfm_dma_cfg_t dma_cfg;
   iopfm_irq_cfg_t irq_cfg [NIRQ];
   assign dma_cfg = iopfm_dma_cfg_t'(dma_cfg_r[11:0]);
   for (genvar i = 0; i < NIRQ; i++) begin : g_cfg
      assign irq_cfg[i] = iopfm_irq_cfg_t'(irq_cfg_r[i*4 +: 4]);
   end

   // Pin input conditioning
   logic [63:0] sync_q, filt_q, filt_en;
   logic [NIRQ-1:0] irq_lvl, irq_rise, irq_fall, irq_ev, irq_fn;
   logic [NDMA-1:0] dma_fn;
   always_comb begin
      filt_en = '0;
      for (int i = 0; i < NIRQ; i++) begin
         filt_en[PIN_IRQ0 + i] = irq_cfg[i].filt_en;
      end
      filt_en[PIN_DMA_REQ0 +: NDMA] = dma_cfg.filt_en;
   end

   iopfm_filt #(.W(NPIN)) u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw(pin_in),
      .filt_en(filt_en),
      .sync_q(sync_q),
      .filt_q(filt_q)
   );

   logic [63:0] fn_mode, fn_out;
   // Zero select bit picks the dedicated role on pins that have one
   assign fn_mode = FN_AVAIL & ~fsel_r;
   assign irq_fn = fn_mode[PIN_IRQ0 +: NIRQ];
   assign dma_fn = fn_mode[PIN_DMA_REQ0 +: NDMA];

   always_comb begin
      for (int i = 0; i < NIRQ; i++) begin
         irq_lvl[i] = irq_fn[i] & (filt_q[PIN_IRQ0 + i] ^ irq_cfg[i].act_low);
      end
   end

   iopfm_edge #(.W(NIRQ)) u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .lvl(irq_lvl),
      .rise(irq_rise),
      .fall(irq_fall)
   );

   always_comb begin
      for (int i = 0; i < NIRQ; i++) begin
         irq_ev[i] = (irq_cfg[i].mode == MODE_RISE && irq_rise[i])
                  || (irq_cfg[i].mode == MODE_FALL && irq_fall[i]);
         ext_irq_to_intc[i] = (irq_cfg[i].mode == MODE_RISE || irq_cfg[i].mode == MODE_FALL)
                            ? pend_r[i] : irq_lvl[i];
      end
   end

   // Bus handshakes
   logic do_wr, rd_take;
   logic [3:0] wr_idx, rd_idx;
   logic [31:0] wd_lo, rd_mux;
   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign do_wr = aw_held_r & w_held_r & ~bvalid_r;
   assign rd_take = s_axi_arvalid & ~rvalid_r;
   assign wr_idx = reg_index(awaddr_r);
   assign rd_idx = reg_index(s_axi_araddr);

   // Pending: write-one clears, a new edge in the same cycle wins
   logic [NIRQ-1:0] pend_clr;
   assign wd_lo = iopfm_strb(RST_ZERO, wdata_r, wstrb_r);
   assign pend_clr = (do_wr && wr_idx == RI_IRQ_PEND) ? wd_lo[NIRQ-1:0] : '0;
   assign pend_nxt = (pend_r & ~pend_clr) | irq_ev;
   assign irq = |(pend_r & mask_r);

   // Input pins read back the sampled level, output pins the latch
   logic [63:0] data_rd;
   assign data_rd = (dir_r & sync_q) | (~dir_r & data_r);

   always_comb begin
      if (rd_idx == RI_DIR_LO) rd_mux = dir_r[31:0];
      else if (rd_idx == RI_DIR_HI) rd_mux = dir_r[63:32];
      else if (rd_idx == RI_FSEL_LO) rd_mux = fsel_r[31:0];
      else if (rd_idx == RI_FSEL_HI) rd_mux = fsel_r[63:32];
      else if (rd_idx == RI_DMA_CFG) rd_mux = dma_cfg_r;
      else if (rd_idx == RI_IRQ_CFG) rd_mux = irq_cfg_r;
      else if (rd_idx == RI_IRQ_PEND) rd_mux = {26'h0000000, pend_r};
      else if (rd_idx == RI_DATA_LO) rd_mux = data_rd[31:0];
      else if (rd_idx == RI_DATA_HI) rd_mux = data_rd[63:32];
      else if (rd_idx == RI_DRV_LO) rd_mux = drv_r[31:0];
      else if (rd_idx == RI_DRV_HI) rd_mux = drv_r[63:32];
      else if (rd_idx == RI_IRQ_MASK) rd_mux = {26'h0000000, mask_r};
      else rd_mux = RST_ZERO;
   end

   // Dedicated output values
   always_comb begin
      fn_out = '0;
      fn_out[PIN_TMR0 +: NTMR] = timer_out;
      fn_out[PIN_DMA_ACK0 +: NDMA] = general_dma_ack ^ dma_cfg.ack_low;
      fn_out[PIN_FS_TX] = fast_serial_transmit;
      fn_out[PIN_FS_DTR] = fast_serial_terminal_ready;
      fn_out[PIN_FS_RTS] = fast_serial_request_to_send;
   end

   // Pin drive: value, enable and pad type
   logic [63:0] gpio_val, pin_val, want_drive;
   assign gpio_val = (rp_state_r == RP_HIGH) ? (data_r | RST_PULSE_PINS) : data_r;
   assign pin_val = (fn_mode & fn_out) | (~fn_mode & gpio_val);
   assign want_drive = (fn_mode & FN_IS_OUT) | (~fn_mode & ~dir_r);
   assign pin_oe_n_nxt = ~(want_drive & (~drv_r | ~pin_val));
   assign pin_out_nxt = pin_val & ~drv_r;
   assign pin_out = pin_out_r;
   assign pin_oe_n = pin_oe_n_r;
   assign general_dma_req = dma_req_r;
   // Idle level on deselected inbound UART lines
   assign fast_serial_receive = ~fn_mode[PIN_FS_RX] | sync_q[PIN_FS_RX];
   assign fast_serial_set_ready = ~fn_mode[PIN_FS_DSR] | sync_q[PIN_FS_DSR];
   assign fast_serial_clear_to_send = ~fn_mode[PIN_FS_CTS] | sync_q[PIN_FS_CTS];
   assign fast_serial_carrier_detect = ~fn_mode[PIN_FS_DCD] | sync_q[PIN_FS_DCD];

   // Bus channel state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= RST_ZERO;
         wdata_r <= RST_ZERO;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_wr) begin
            w_held_r <= 1'b0;
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_idx == RI_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= RST_ZERO;
         rresp_r <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= (rd_idx == RI_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_r <= {RST_DIR_HI, RST_DIR_LO};
         fsel_r <= {RST_FSEL_HI, RST_FSEL_LO};
         dma_cfg_r <= RST_ZERO;
         irq_cfg_r <= RST_ZERO;
         data_r <= '0;
         drv_r <= '0;
         mask_r <= '0;
      end else if (do_wr) begin
         if (wr_idx == RI_DIR_LO) dir_r[31:0] <= iopfm_strb(dir_r[31:0], wdata_r, wstrb_r);
         if (wr_idx == RI_DIR_HI) dir_r[63:32] <= iopfm_strb(dir_r[63:32], wdata_r, wstrb_r);
         if (wr_idx == RI_FSEL_LO) fsel_r[31:0] <= iopfm_strb(fsel_r[31:0], wdata_r, wstrb_r);
         if (wr_idx == RI_FSEL_HI) fsel_r[63:32] <= iopfm_strb(fsel_r[63:32], wdata_r, wstrb_r);
         if (wr_idx == RI_DMA_CFG) dma_cfg_r <= DMA_CFG_BITS & iopfm_strb(dma_cfg_r, wdata_r, wstrb_r);
         if (wr_idx == RI_IRQ_CFG) irq_cfg_r <= IRQ_CFG_BITS & iopfm_strb(irq_cfg_r, wdata_r, wstrb_r);
         if (wr_idx == RI_DATA_LO) data_r[31:0] <= iopfm_strb(data_r[31:0], wdata_r, wstrb_r);
         if (wr_idx == RI_DATA_HI) data_r[63:32] <= iopfm_strb(data_r[63:32], wdata_r, wstrb_r);
         if (wr_idx == RI_DRV_LO) drv_r[31:0] <= iopfm_strb(drv_r[31:0], wdata_r, wstrb_r);
         if (wr_idx == RI_DRV_HI) drv_r[63:32] <= iopfm_strb(drv_r[63:32], wdata_r, wstrb_r);
         if (wr_idx == RI_IRQ_MASK) mask_r <= wd_lo[NIRQ-1:0];
      end
   end

   // Pins, DMA requests and pending bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= '0;
         dma_req_r <= '0;
         pin_out_r <= RST_PULSE_PINS;
         pin_oe_n_r <= ~RST_PULSE_PINS;
      end else begin
         pend_r <= pend_nxt;
         dma_req_r <= dma_fn & (filt_q[PIN_DMA_REQ0 +: NDMA] ^ dma_cfg.req_low);
         pin_out_r <= pin_out_nxt;
         pin_oe_n_r <= pin_oe_n_nxt;
      end
   end

   // External-reset pulse timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rp_state_r <= RP_HIGH;
         rp_cnt_r <= RESET_PULSE_CYC;
      end else begin
         case (rp_state_r)
            RP_HIGH: begin
               if (rp_cnt_r <= 16'h0001) begin
                  rp_state_r <= RP_DONE;
               end
               rp_cnt_r <= rp_cnt_r - 16'h0001;
            end
            default: begin
               rp_cnt_r <= 16'h0000;
            end
         endcase
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PIN14_DMA: assert property (!fsel_r[14] |=> general_dma_req[0] == ($past(filt_q[14]) ^ $past(dma_cfg.req_low[0]))) else $error("pin 14 request not forwarded");
   AST_GPIO_OUT: assert property (fsel_r[12] && !dir_r[12] && !drv_r[12] |=> pin_out[12] == $past(data_r[12]) && !pin_oe_n[12]) else $error("GPIO output not driven");
   AST_UART_TX: assert property (aresetn && !fsel_r[32+4] && !drv_r[PIN_FS_TX] |=> pin_out[PIN_FS_TX] == $past(fast_serial_transmit) && !pin_oe_n[PIN_FS_TX]) else $error("UART transmit not routed");
   AST_UART_GPIO: assert property (fsel_r[32+3] |-> fast_serial_receive) else $error("UART receive not idle in GPIO role");
   AST_IRQ_LEVEL: assert property (irq_cfg[0].mode == MODE_LEVEL && !fsel_r[0] |-> ext_irq_to_intc[0] == (filt_q[0] ^ irq_cfg[0].act_low)) else $error("level interrupt not passed through");
   AST_PEND_SET: assert property (irq_ev[0] |=> pend_r[0] && ext_irq_to_intc[0] == (irq_cfg[0].mode != MODE_LEVEL)) else $error("edge did not latch pending");
   AST_PEND_CLR: assert property (pend_clr[0] && !irq_ev[0] |=> !pend_r[0]) else $error("write one did not clear pending");
   AST_PEND_HOLD: assert property (pend_r[0] && !pend_clr[0] |=> pend_r[0]) else $error("pending bit dropped uncleared");
   AST_RD_INPUT: assert property (rd_take && rd_idx == RI_DATA_LO && dir_r[0] |=> s_axi_rdata[0] == $past(sync_q[0])) else $error("input pin not read back");
   AST_OPEN_DRAIN: assert property (drv_r[12] |=> !pin_out[12]) else $error("open-drain pin drove high");
   AST_DIR_IN: assert property (fsel_r[13] && dir_r[13] |=> pin_oe_n[13]) else $error("input pin was driven");
   AST_RST_PULSE: assert property (rp_state_r == RP_HIGH && fsel_r[18] && !dir_r[18] && !drv_r[18] |=> pin_out[18]) else $error("reset pulse pin not high");
   AST_IRQ_OUT: assert property ((pend_r & mask_r) != '0 |-> irq) else $error("unmasked pending without interrupt");
endmodule : iopfm_top
`default_nettype wire

// File: testbench/iopfm_pins.sv
// Pad model: outside devices and the block's drivers resolved per pin.
// Assumes the bench sets the outside level of every pad.
`default_nettype none
module iopfm_pins
   import iopfm_pkg::*;
(
   input wire logic [NPIN-1:0] pin_out,
   input wire logic [NPIN-1:0] pin_oe_n,
   input wire logic [NPIN-1:0] ext_lvl,
   output logic [NPIN-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driven pad wins, else the outside level
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule : iopfm_pins
`default_nettype wire

// File: testbench/iopfm_top_test.sv
// Self-checking bench of the I/O function mux top.
// Assumes the pad model on the pins and a short reset pulse.
`default_nettype none
module iopfm_top_test
   import iopfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, q;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [NPIN-1:0] ext_lvl = 64'h0;
   logic [3:0] dma_ack = 4'h0;
   logic [5:0] tmr = 6'h0;
   logic fs_tx = 1'h0;
   logic [1:0] r;
   wire logic awready, wready, bvalid, arready, rvalid, irq, rx;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [NPIN-1:0] pin_in, pin_out, pin_oe_n;
   wire logic [5:0] to_intc;
   wire logic [3:0] dreq;
   int error_cnt = 0;
   int tests_run = 0;
   iopfm_top #(.RESET_PULSE_CYC(16'h0004)) u_iopfm_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_irq_to_intc(to_intc),
      .irq(irq), .general_dma_req(dreq), .general_dma_ack(dma_ack), .timer_out(tmr),
      .fast_serial_transmit(fs_tx), .fast_serial_terminal_ready(fs_tx),
      .fast_serial_request_to_send(1'h0), .fast_serial_receive(rx), .fast_serial_set_ready(),
      .fast_serial_clear_to_send(), .fast_serial_carrier_detect());
   iopfm_pins u_iopfm_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl),
      .pin_in(pin_in));
   task summarize;
      $display("tests %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   task chk(input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %0t: got %h, expected %h", $time, s, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   task wr(input logic [31:0] a, input logic [31:0] d);
      logic ha, hw, got;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge aclk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         got = bvalid;
         @(posedge aclk);
         if (ha) awvalid <= 1'h0;
         if (hw) wvalid <= 1'h0;
      end while (!got);
      bready <= 1'h0;
   endtask : wr
   task rd(input logic [31:0] a);
      logic ha, got;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge aclk);
         ha = arvalid && arready;
         got = rvalid;
         q = rdata;
         r = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'h0;
      end while (!got);
      rready <= 1'h0;
   endtask : rd
   task rc(input logic [31:0] a, input logic [31:0] e);
      rd(a);
      chk(q, e);
   endtask : rc
   task t_reset;
      chk(pin_out[27:18], 10'h3FF);
      cyc(8);
      chk(pin_out[27:18], 10'h000);
      rc(ADDR_FSEL_LO, 32'h0FFFFF00);
      rc(ADDR_FSEL_HI, 32'hFFFFFC07);
      rc(ADDR_DRV_HI, 32'h0);
      rc(ADDR_IRQ_PEND, 32'h0);
      rd(32'hF0030030);
      chk(r, RESP_SLVERR);
      $display("reset test done");
   endtask : t_reset
   task t_gpio;
      wr(ADDR_DIR_LO, 32'hF003EFFF);
      wr(ADDR_DATA_LO, 32'h00001000);
      cyc(2);
      chk({pin_oe_n[12], pin_out[12]}, 2'h1);
      wr(ADDR_DRV_LO, 32'h00001000);
      cyc(2);
      chk(pin_oe_n[12], 1'h1);
      ext_lvl[13] <= 1'h1;
      cyc(4);
      rd(ADDR_DATA_LO);
      chk(q[13], 1'h1);
      $display("gpio test done");
   endtask : t_gpio
   task t_irq;
      logic acc;
      wr(ADDR_IRQ_CFG, 32'h00012084);
      wr(ADDR_IRQ_MASK, 32'h3);
      ext_lvl[2:0] <= 3'h7;
      cyc(6);
      chk(to_intc[3:0], 4'hD);
      rc(ADDR_IRQ_PEND, 32'h1);
      chk(irq, 1'h1);
      wr(ADDR_IRQ_PEND, 32'h1);
      ext_lvl[2:0] <= 3'h0;
      cyc(6);
      rc(ADDR_IRQ_PEND, 32'h2);
      chk({irq, to_intc[2]}, 2'h2);
      wr(ADDR_IRQ_PEND, 32'h2);
      rc(ADDR_IRQ_PEND, 32'h0);
      chk(irq, 1'h0);
      acc = 1'h0;
      ext_lvl[4] <= 1'h1;
      cyc(1);
      ext_lvl[4] <= 1'h0;
      repeat (6) begin
         @(negedge aclk);
         acc = acc | to_intc[4];
      end
      chk(acc, 1'h0);
      $display("interrupt test done");
   endtask : t_irq
   task t_func;
      wr(ADDR_FSEL_LO, 32'h0FFFBF00);
      ext_lvl[14] <= 1'h1;
      dma_ack <= 4'h1;
      tmr <= 6'h01;
      fs_tx <= 1'h1;
      cyc(6);
      chk(dreq, 4'h1);
      chk({pin_out[37], pin_out[36], pin_out[28], pin_out[6], rx}, 5'h1E);
      wr(ADDR_DMA_CFG, 32'h00000010);
      cyc(4);
      chk(dreq, 4'h0);
      wr(ADDR_FSEL_HI, 32'hFFFFFFFF);
      ext_lvl[35] <= 1'h0;
      cyc(6);
      chk(rx, 1'h1);
      $display("function test done");
   endtask : t_func
   initial begin
      forever begin
         #2.5 aclk = ~aclk;
      end
   end
   initial begin
      cyc(4000);
      error_cnt++;
      summarize();
   end
   initial begin
      cyc(20);
      aresetn <= 1'h1;
      t_reset();
      t_gpio();
      t_irq();
      t_func();
      summarize();
   end
endmodule : iopfm_top_test
`default_nettype wire
